// File: include/rtc16_defs.svh
// Register indices, field positions, reset values and timing counts of the real-time counter.
`ifndef RTC16_DEFS_SVH
`define RTC16_DEFS_SVH

// ==========================================
// Register indices (byte address is four times the index)
`define RTC16_IDX_CTRL 4'h0
`define RTC16_IDX_STATUS 4'h1
`define RTC16_IDX_LEVELS 4'h2
`define RTC16_IDX_FLAGS 4'h3
`define RTC16_IDX_TEMP 4'h4
`define RTC16_IDX_COUNT_LO 4'h8
`define RTC16_IDX_COUNT_HI 4'h9
`define RTC16_IDX_PERIOD_LO 4'hA
`define RTC16_IDX_PERIOD_HI 4'hB
`define RTC16_IDX_CMPL 4'hC
`define RTC16_IDX_CMPH 4'hD

// ==========================================
// Field positions
`define RTC16_DIV_MSB 2
`define RTC16_WRAP_LVL_MSB 1
`define RTC16_WRAP_LVL_LSB 0
`define RTC16_MATCH_LVL_MSB 3
`define RTC16_MATCH_LVL_LSB 2
`define RTC16_WRAP_BIT 0
`define RTC16_MATCH_BIT 1
`define RTC16_SYNC_BIT 0

// ==========================================
// Reset values and constants
`define RTC16_DIV_OFF 3'h0
`define RTC16_CNT_RST 16'h0000
`define RTC16_PER_RST 16'hFFFF
`define RTC16_CMP_RST 16'h0000
`define RTC16_BYTE_RST 8'h00
`define RTC16_LVL_OFF 2'h0
`define RTC16_PRE_ZERO 10'h000
`define RTC16_SKIP_PER0 2'h2
`define RTC16_SKIP_PER1 2'h1
`define RTC16_SKIP_NONE 2'h0
`define RTC16_PER_ONE 16'h0001
`define RTC16_CNT_ONE 16'h0001

`endif

// File: include/rtc16_pkg.sv
// Types shared by the real-time counter design.
package rtc16_pkg;

	// ==========================================
	// Crossing of a committed update toward the reference domain.
	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_WAIT1,
		SYNC_WAIT2
	} rtc16_sync_t;

	// ==========================================
	// Staged update waiting for the crossing to finish.
	typedef struct packed {
		logic load_div;
		logic load_cnt;
		logic load_per;
		logic load_cmp;
		logic [2:0] div;
		logic [15:0] cnt;
		logic [15:0] period_value;
		logic [15:0] cmp;
	} rtc16_stage_t;

	// ==========================================
	// Interrupt request levels toward the interrupt controller.
	typedef struct packed {
		logic [1:0] match_lvl;
		logic [1:0] wrap_lvl;
	} rtc16_irq_t;

endpackage

// File: hw/rtc16_counter_regs.sv
// 16-bit real-time counter with byte-wide Wishbone registers.
`timescale 1ns/10ps
// Functional notes
// - Divider code 000 stops; others divide 1..1024.
// - Sync pending bit set while update crosses.
// - Match irq level in bits 3:2 gates request.
// - Wrap irq level in bits 1:0 gates request.
// - Match flag set on step; vector/W1C clears.
// - Wrap flag set on step; vector/W1C clears.
// - Low write and low read use staging byte.
// - Counter increments on each prescaled edge.
// - Updates apply two reference edges after commit.
// - Count equal period sets wrap, clears count.
// - Count equal compare sets match flag.
// - Compare above period never matches.
// - Divider upper bits zero, divider resets off.
// - Events every third, second, or each occurrence.
`include "rtc16_defs.svh"

module rtc16_counter_regs
	import rtc16_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic SYS_RST_IN,
	// Wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [5:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Reference clock, sampled as a level
	input wire logic REF_CLK_IN,
	// Interrupt controller
	input wire logic MATCH_VEC_TAKEN_IN,
	input wire logic WRAP_VEC_TAKEN_IN,
	output logic [1:0] MATCH_IRQ_OUT,
	output logic [1:0] WRAP_IRQ_OUT,
	// Events
	output logic MATCH_EVT_OUT,
	output logic WRAP_EVT_OUT
);

	// ==========================================
	// Helpers
	function automatic logic [9:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'h1: div_mask = 10'h000;
			3'h2: div_mask = 10'h001;
			3'h3: div_mask = 10'h007;
			3'h4: div_mask = 10'h00F;
			3'h5: div_mask = 10'h03F;
			3'h6: div_mask = 10'h0FF;
			3'h7: div_mask = 10'h3FF;
			default: div_mask = 10'h000;
		endcase
	endfunction

	function automatic logic [1:0] skip_load(input logic [15:0] period_value);
		if (period_value == `RTC16_CNT_RST) begin
			skip_load = `RTC16_SKIP_PER0;
		end else if (period_value == `RTC16_PER_ONE) begin
			skip_load = `RTC16_SKIP_PER1;
		end else begin
			skip_load = `RTC16_SKIP_NONE;
		end
	endfunction

	// ==========================================
	// State
	logic [2:0] div_q;
	logic [9:0] pre_q, pre_d;
	logic [15:0] cnt_q, cnt_d, per_q, cmp_q;
	logic [7:0] temp_q, temp_d;
	logic [3:0] lvl_q;
	logic wrap_flag_q, match_flag_q;
	logic ref_prev_q;
	logic ack_q;
	logic [31:0] dat_q;
	rtc16_sync_t sync_q, sync_d;
	rtc16_stage_t stage_q, stage_d;
	rtc16_irq_t irq_w;
	logic [1:0] wrap_skip_q, match_skip_q;
	logic wrap_evt_q, match_evt_q;

	// ==========================================
	// Bus decode
	wire logic [3:0] idx = WB_ADR_IN[5:2];
	wire logic req = WB_CYC_IN && WB_STB_IN && !ack_q;
	wire logic wr = req && WB_WE_IN && WB_SEL_IN[0];
	wire logic rd = req && !WB_WE_IN;
	wire logic [7:0] wdat = WB_DAT_IN[7:0];
	wire logic wr_ctrl = wr && (idx == `RTC16_IDX_CTRL);
	wire logic wr_lvl = wr && (idx == `RTC16_IDX_LEVELS);
	wire logic wr_flags = wr && (idx == `RTC16_IDX_FLAGS);
	wire logic wr_temp = wr && (idx == `RTC16_IDX_TEMP);
	wire logic wr_low = wr && ((idx == `RTC16_IDX_COUNT_LO) || (idx == `RTC16_IDX_PERIOD_LO)
		|| (idx == `RTC16_IDX_CMPL));
	wire logic wr_count_hi = wr && (idx == `RTC16_IDX_COUNT_HI);
	wire logic wr_period_hi = wr && (idx == `RTC16_IDX_PERIOD_HI);
	wire logic wr_cmph = wr && (idx == `RTC16_IDX_CMPH);
	wire logic commit = wr_count_hi || wr_period_hi || wr_cmph || wr_ctrl;
	wire logic rd_low = rd && ((idx == `RTC16_IDX_COUNT_LO) || (idx == `RTC16_IDX_PERIOD_LO)
		|| (idx == `RTC16_IDX_CMPL));
	wire logic pending = (sync_q != SYNC_IDLE);

	// Read selection; unmapped indices and reserved bits read as zero.
	logic [7:0] rd_mux;
	always_comb begin
		case (idx)
			`RTC16_IDX_CTRL: rd_mux = {5'h00, div_q};
			`RTC16_IDX_STATUS: rd_mux = {7'h00, pending};
			`RTC16_IDX_LEVELS: rd_mux = {4'h0, lvl_q};
			`RTC16_IDX_FLAGS: rd_mux = {6'h00, match_flag_q, wrap_flag_q};
			`RTC16_IDX_TEMP: rd_mux = temp_q;
			`RTC16_IDX_COUNT_LO: rd_mux = cnt_q[7:0];
			`RTC16_IDX_COUNT_HI: rd_mux = cnt_q[15:8];
			`RTC16_IDX_PERIOD_LO: rd_mux = per_q[7:0];
			`RTC16_IDX_PERIOD_HI: rd_mux = per_q[15:8];
			`RTC16_IDX_CMPL: rd_mux = cmp_q[7:0];
			`RTC16_IDX_CMPH: rd_mux = cmp_q[15:8];
			default: rd_mux = `RTC16_BYTE_RST;
		endcase
	end

	// Matching high byte captured on a low-byte read.
	logic [7:0] hi_mux;
	always_comb begin
		case (idx)
			`RTC16_IDX_COUNT_LO: hi_mux = cnt_q[15:8];
			`RTC16_IDX_PERIOD_LO: hi_mux = per_q[15:8];
			default: hi_mux = cmp_q[15:8];
		endcase
	end

	always_comb begin
		temp_d = temp_q;
		if (wr_temp || wr_low) begin
			temp_d = wdat;
		end else if (rd_low) begin
			temp_d = hi_mux;
		end
	end

	// ==========================================
	// Reference edge, prescaler and counter step
	wire logic ref_edge = REF_CLK_IN && !ref_prev_q;
	wire logic [9:0] mask = div_mask(div_q);
	wire logic tick = ref_edge && (div_q != `RTC16_DIV_OFF) && ((pre_q & mask) == mask);
	wire logic wrap_hit = tick && (cnt_q == per_q);
	wire logic match_hit = tick && (cnt_q == cmp_q) && (cmp_q <= per_q);
	wire logic apply = (sync_q == SYNC_WAIT2) && ref_edge;

	always_comb begin
		pre_d = pre_q;
		if (ref_edge && (div_q != `RTC16_DIV_OFF)) begin
			pre_d = tick ? `RTC16_PRE_ZERO : 10'(pre_q + 10'h001);
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (apply && stage_q.load_cnt) begin
			cnt_d = stage_q.cnt;
		end else if (wrap_hit) begin
			cnt_d = `RTC16_CNT_RST;
		end else if (tick) begin
			cnt_d = 16'(cnt_q + `RTC16_CNT_ONE);
		end
	end

	// ==========================================
	// Crossing: a commit waits for two reference edges, then lands.
	always_comb begin
		sync_d = sync_q;
		stage_d = stage_q;
		if (apply) begin
			stage_d.load_div = 1'b0;
			stage_d.load_cnt = 1'b0;
			stage_d.load_per = 1'b0;
			stage_d.load_cmp = 1'b0;
		end
		case (sync_q)
			SYNC_IDLE: sync_d = SYNC_IDLE;
			SYNC_WAIT1: sync_d = ref_edge ? SYNC_WAIT2 : SYNC_WAIT1;
			SYNC_WAIT2: sync_d = ref_edge ? SYNC_IDLE : SYNC_WAIT2;
			default: sync_d = SYNC_IDLE;
		endcase
		// A late commit restarts the wait so the newest value also gets two edges.
		if (commit) begin
			sync_d = SYNC_WAIT1;
		end
		if (wr_ctrl) begin
			stage_d.load_div = 1'b1;
			stage_d.div = wdat[`RTC16_DIV_MSB:0];
		end
		if (wr_count_hi) begin
			stage_d.load_cnt = 1'b1;
			stage_d.cnt = {wdat, temp_q};
		end
		if (wr_period_hi) begin
			stage_d.load_per = 1'b1;
			stage_d.period_value = {wdat, temp_q};
		end
		if (wr_cmph) begin
			stage_d.load_cmp = 1'b1;
			stage_d.cmp = {wdat, temp_q};
		end
	end

	// ==========================================
	// Interrupt requests and events
	assign irq_w.match_lvl = match_flag_q ? lvl_q[`RTC16_MATCH_LVL_MSB:`RTC16_MATCH_LVL_LSB]
		: `RTC16_LVL_OFF;
	assign irq_w.wrap_lvl = wrap_flag_q ? lvl_q[`RTC16_WRAP_LVL_MSB:`RTC16_WRAP_LVL_LSB]
		: `RTC16_LVL_OFF;
	assign MATCH_IRQ_OUT = irq_w.match_lvl;
	assign WRAP_IRQ_OUT = irq_w.wrap_lvl;
	assign MATCH_EVT_OUT = match_evt_q;
	assign WRAP_EVT_OUT = wrap_evt_q;
	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = dat_q;

	// Periods 0 and 1 lose events: after each emitted one, skip_load(per_q) passes over the next two or one hits.
	wire logic wrap_emit = wrap_hit && (wrap_skip_q == `RTC16_SKIP_NONE);
	wire logic match_emit = match_hit && (match_skip_q == `RTC16_SKIP_NONE);

	// ==========================================
	// Registers
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			div_q <= `RTC16_DIV_OFF;
			pre_q <= `RTC16_PRE_ZERO;
			cnt_q <= `RTC16_CNT_RST;
			per_q <= `RTC16_PER_RST;
			cmp_q <= `RTC16_CMP_RST;
			temp_q <= `RTC16_BYTE_RST;
			lvl_q <= 4'h0;
			ref_prev_q <= 1'b0;
			sync_q <= SYNC_IDLE;
			stage_q <= '0;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			div_q <= (apply && stage_q.load_div) ? stage_q.div : div_q;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			per_q <= (apply && stage_q.load_per) ? stage_q.period_value : per_q;
			cmp_q <= (apply && stage_q.load_cmp) ? stage_q.cmp : cmp_q;
			temp_q <= temp_d;
			lvl_q <= wr_lvl ? wdat[3:0] : lvl_q;
			ref_prev_q <= REF_CLK_IN;
			sync_q <= sync_d;
			stage_q <= stage_d;
			ack_q <= req;
			dat_q <= rd ? {24'h000000, rd_mux} : dat_q;
		end
	end

	// Hardware set wins over a clear in the same cycle.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			wrap_flag_q <= 1'b0;
			match_flag_q <= 1'b0;
		end else begin
			wrap_flag_q <= wrap_hit || (wrap_flag_q && !WRAP_VEC_TAKEN_IN
				&& !(wr_flags && wdat[`RTC16_WRAP_BIT]));
			match_flag_q <= match_hit || (match_flag_q && !MATCH_VEC_TAKEN_IN
				&& !(wr_flags && wdat[`RTC16_MATCH_BIT]));
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			wrap_skip_q <= `RTC16_SKIP_NONE;
			match_skip_q <= `RTC16_SKIP_NONE;
			wrap_evt_q <= 1'b0;
			match_evt_q <= 1'b0;
		end else begin
			wrap_evt_q <= wrap_emit;
			match_evt_q <= match_emit;
			if (wrap_hit) begin
				wrap_skip_q <= wrap_emit ? skip_load(per_q) : 2'(wrap_skip_q - 2'h1);
			end
			if (match_hit) begin
				match_skip_q <= match_emit ? skip_load(per_q) : 2'(match_skip_q - 2'h1);
			end
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	divider_off_a: assert property (div_q == `RTC16_DIV_OFF |-> !tick)
		else $error("counter stepped while divider off");
	sync_pending_a: assert property (commit |=> pending [*2])
		else $error("pending bit not held after commit");
	match_irq_a: assert property (match_flag_q && lvl_q[3:2] != 2'h0 |-> MATCH_IRQ_OUT == lvl_q[3:2])
		else $error("match request level wrong");
	wrap_irq_a: assert property (!wrap_flag_q |-> WRAP_IRQ_OUT == 2'h0)
		else $error("wrap request without flag");
	match_flag_a: assert property (match_hit |=> match_flag_q)
		else $error("match flag not set");
	wrap_clear_a: assert property (wrap_hit && !(apply && stage_q.load_cnt)
		|=> wrap_flag_q && cnt_q == 16'h0000)
		else $error("wrap did not set flag and clear count");
	temp_hold_a: assert property (wr_low |=> temp_q == $past(wdat))
		else $error("low byte not staged");
	count_step_a: assert property (tick && !wrap_hit && !(apply && stage_q.load_cnt)
		|=> cnt_q == 16'($past(cnt_q) + 16'h0001))
		else $error("counter did not increment");
	sync_land_a: assert property (sync_q == SYNC_WAIT2 && ref_edge && !commit
		|=> !pending && (!$past(stage_q.load_per) || per_q == $past(stage_q.period_value)))
		else $error("update did not land");
	no_match_a: assert property (cmp_q > per_q |-> !match_hit)
		else $error("match above period");
	ctrl_zero_a: assert property (rd && idx == `RTC16_IDX_CTRL |=> dat_q[7:3] == 5'h00)
		else $error("reserved divider bits nonzero");
	evt_every_a: assert property (wrap_hit && per_q > 16'h0002 && wrap_skip_q == 2'h0
		|=> WRAP_EVT_OUT)
		else $error("wrap event missing");

	wrap_seen_c: cover property (wrap_hit ##[1:50] WRAP_VEC_TAKEN_IN);
	sync_done_c: cover property (commit ##[1:100] !pending);
	match_evt_c: cover property (match_hit && !match_emit);

endmodule

// File: dv/rtc16_ref_src.sv
// Reference clock source standing in for the slow real-time oscillator.
`timescale 1ns/10ps
module rtc16_ref_src #(
	parameter int HALF = 3
) (
	input wire logic clk_in,
	input wire logic run_in,
	output logic ref_out
);
	int n;
	// ==========================================
	// Divided clock.
	// The line stands low while stopped, so that no stray edge is seen.
	initial begin
		n = 0;
		ref_out = 1'b0;
	end
	always @(posedge clk_in) begin
		if (!run_in) begin
			n <= 0;
			ref_out <= 1'b0;
		end else if (n == HALF - 1) begin
			n <= 0;
			ref_out <= !ref_out;
		end else begin
			n <= n + 1;
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench of the real-time counter registers.
`timescale 1ns/10ps
module tb;
	import rtc16_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, refc, refp = 1'b0, mvec = 1'b0, wvec = 1'b0;
	logic [1:0] mirq, wirq;
	logic mev, wev;
	int n_wev = 0, n_mev = 0, w0, m0;
	logic [7:0] q, lo, r;
	int bad_count = 0, n_compared = 0, edges = 0, cycles = 0, e0, c0, c1;
	int divs [8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
	rtc16_ref_src i_rtc16_ref_src (.clk_in(clk), .run_in(run), .ref_out(refc));
	rtc16_counter_regs i_rtc16_counter_regs (.MCLK_IN(clk), .SYS_RST_IN(rst),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'h1), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
		.REF_CLK_IN(refc), .MATCH_VEC_TAKEN_IN(mvec), .WRAP_VEC_TAKEN_IN(wvec),
		.MATCH_IRQ_OUT(mirq), .WRAP_IRQ_OUT(wirq), .MATCH_EVT_OUT(mev), .WRAP_EVT_OUT(wev));
	always #20 clk = !clk;
	// ==========================================
	// Edge count of the reference, and the hang limit.
	always @(posedge clk) begin
		refp <= refc;
		if (refc && !refp)
			edges <= edges + 1;
		cycles <= cycles + 1;
		if (wev === 1'b1)
			n_wev <= n_wev + 1;
		if (mev === 1'b1)
			n_mev <= n_mev + 1;
		if (cycles == 90000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// ==========================================
	// Classic single Wishbone cycle; held until ack is sampled.
	task automatic bus(input logic [3:0] idx, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			n = n + 1;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		if (n >= 50)
			chk(8'h00, 8'hFF, "no ack");
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] idx, input logic [7:0] exp, input string m);
		bus(idx, 1'b0, 8'h00);
		chk(q, exp, m);
	endtask
	task automatic wr16(input logic [3:0] idx, input logic [15:0] v);
		bus(idx, 1'b1, v[7:0]);
		bus(idx + 4'h1, 1'b1, v[15:8]);
	endtask
	task automatic wsync();
		int n;
		n = 0;
		do begin
			bus(4'h1, 1'b0, 8'h00);
			n = n + 1;
		end while (q[0] !== 1'b0 && n < 200);
		chk(q, 8'h00, "pending stuck");
	endtask
	task automatic run_edges(input int k);
		e0 = edges;
		while (edges - e0 < k)
			@(posedge clk);
	endtask
	initial begin
		void'($urandom(19971));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		run <= 1'b1;
		// ==========================================
		// Reset values and an unmapped index.
		foreach (divs[i])
			if (i < 5)
				rdc(i[3:0], 8'h00, "reset value");
		rdc(4'h5, 8'h00, "unmapped");
		rdc(4'hA, 8'hFF, "period reset");
		$display("test reset done");
		// ==========================================
		// Level register and a staged 16-bit write.
		r = 8'($urandom()) & 8'h0F;
		bus(4'h2, 1'b1, r);
		rdc(4'h2, r, "levels");
		lo = 8'($urandom());
		wr16(4'hC, {8'h7F, lo});
		rdc(4'h1, 8'h01, "pending set");
		wsync();
		rdc(4'hC, lo, "compare low");
		rdc(4'h4, 8'h7F, "staged high");
		$display("test staging done");
		// ==========================================
		// Wrap and match flags, levels and clearing.
		wr16(4'hA, 16'h0004);
		wsync();
		wr16(4'hC, 16'h0002);
		wsync();
		bus(4'h2, 1'b1, 8'h09);
		w0 = n_wev;
		m0 = n_mev;
		bus(4'h0, 1'b1, 8'h01);
		wsync();
		run_edges(30);
		bus(4'h0, 1'b1, 8'h00);
		wsync();
		rdc(4'h3, 8'h03, "both flags");
		// Period four wraps every fifth step, so about 32 steps give six events.
		chk(8'((n_wev - w0) >= 5 && (n_wev - w0) <= 7), 8'h01, "wrap events");
		chk(8'((n_mev - m0) >= 5 && (n_mev - m0) <= 7), 8'h01, "match events");
		chk({6'h00, wirq}, 8'h01, "wrap level");
		chk({6'h00, mirq}, 8'h02, "match level");
		bus(4'h8, 1'b0, 8'h00);
		chk(8'(q < 8'h05), 8'h01, "count above period");
		bus(4'h3, 1'b1, 8'h01);
		rdc(4'h3, 8'h02, "wrap cleared");
		@(posedge clk);
		mvec <= 1'b1;
		@(posedge clk);
		mvec <= 1'b0;
		rdc(4'h3, 8'h00, "match cleared");
		chk({4'h0, mirq, wirq}, 8'h00, "irq idle");
		$display("test flags done");
		// ==========================================
		// Compare above period never matches.
		wr16(4'hC, 16'h0007);
		m0 = n_mev;
		wsync();
		bus(4'h0, 1'b1, 8'h01);
		wsync();
		run_edges(30);
		bus(4'h0, 1'b1, 8'h00);
		wsync();
		rdc(4'h3, 8'h01, "no match");
		chk(8'(n_mev - m0), 8'h00, "no match event");
		chk({6'h00, mirq}, 8'h00, "no match irq");
		$display("test compare done");
		// ==========================================
		// Every divider code from 1 to 7 steps at its own rate.
		wr16(4'hA, 16'hFFFF);
		wsync();
		for (int c = 1; c < 8; c++) begin
			bus(4'h0, 1'b1, {5'h1F, c[2:0]});
			wsync();
			rdc(4'h0, {5'h00, c[2:0]}, "divider code");
			bus(4'h8, 1'b0, 8'h00);
			lo = q;
			bus(4'h4, 1'b0, 8'h00);
			c0 = {q, lo};
			run_edges(3 * divs[c]);
			bus(4'h8, 1'b0, 8'h00);
			lo = q;
			bus(4'h4, 1'b0, 8'h00);
			c1 = {q, lo};
			chk(8'(c1 - c0 >= 2 && c1 - c0 <= 4), 8'h01, "step rate");
		end
		$display("test divider done");
		end_of_test();
	end
endmodule
